// ### include/serial_multi_slave_pkg.sv
// Constants for the clocked serial multi-slave channel: register offsets,
// field positions, reset values and the transfer state type.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package serial_multi_slave_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [5:0] TX_BUFFER_OFF      = 6'h00;
	localparam logic [5:0] RX_BUFFER_OFF      = 6'h04;
	localparam logic [5:0] BAUD_DIVIDER_OFF   = 6'h08;
	localparam logic [5:0] SERIAL_MODE_OFF    = 6'h0C;
	localparam logic [5:0] XFER_CONTROL0_OFF  = 6'h10;
	localparam logic [5:0] XFER_CONTROL1_OFF  = 6'h14;
	localparam logic [5:0] SPECIAL_MODE1_OFF  = 6'h18;
	localparam logic [5:0] SPECIAL_MODE2_OFF  = 6'h1C;
	localparam logic [5:0] SPECIAL_MODE3_OFF  = 6'h20;
	localparam logic [5:0] SPECIAL_MODE4_OFF  = 6'h24;
	localparam logic [5:0] COMMON_CONTROL_OFF = 6'h28;

	// Serial mode register fields
	localparam int         MODE_SEL_LSB       = 0;
	localparam int         CLOCK_SOURCE_DIR   = 3;
	localparam int         LINE_POL_INVERT    = 7;
	localparam logic [2:0] MULTI_SLAVE_MODE   = 3'h1;

	// Control register 0 fields
	localparam int BAUD_SRC_LSB       = 0;
	localparam int HANDSHAKE_FUNC_SEL = 2;
	localparam int SHIFT_EMPTY_FLAG   = 3;
	localparam int HANDSHAKE_DISABLE  = 4;
	localparam int TXD_FORMAT_SEL     = 5;
	localparam int CLOCK_EDGE_POL     = 6;
	localparam int BIT_ORDER_SEL      = 7;

	// Control register 1 fields
	localparam int TX_ENABLE       = 0;
	localparam int TX_BUF_EMPTY    = 1;
	localparam int RX_ENABLE       = 2;
	localparam int RX_DONE         = 3;
	localparam int CH2_TX_IRQ_SRC  = 4;
	localparam int CH2_CONT_RX     = 5;

	// Special mode 3 and common control fields
	localparam int CLOCK_PHASE_SEL = 1;
	localparam int CH0_TX_IRQ_SRC  = 0;
	localparam int CH1_TX_IRQ_SRC  = 1;
	localparam int MULTI_CLK_SEL   = 4;
	localparam int MULTI_CLK_EN    = 5;

	// Receive buffer word: data in 7..0, overrun flag here
	localparam int RX_OVERRUN_BIT = 12;

	// Reset values
	localparam logic [7:0] REG8_RST       = 8'h00;
	localparam logic [7:0] CTL1_STORE_RST = 8'h00;
	localparam logic       TX_EMPTY_RST   = 1'b1;

	// Bit and edge counts of one 8-bit transfer
	localparam logic [3:0] BITS_PER_XFER  = 4'h8;
	localparam logic [4:0] EDGES_PER_XFER = 5'h10;

	typedef enum logic {
		ST_IDLE,
		ST_XFER
	} xfer_state_t;

endpackage

// ### src/serial_multi_slave.sv
// One channel of the clocked serial multi-slave mode: registers, baud
// generator, 8-bit shifter with selectable clock polarity and phase.
// Assumes an Avalon-MM master on clk_sys_in; the serial clock pin, when
// the channel is a slave, and the receive pin are asynchronous.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns

module serial_multi_slave #(
	parameter int CH_INDEX = 0
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic [5:0]  address_in,
	input  wire logic        read_in,
	input  wire logic        write_in,
	input  wire logic [31:0] writedata_in,
	input  wire logic [3:0]  byteenable_in,
	output logic      [31:0] readdata_out,
	output logic             waitrequest_out,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe_out,
	input  wire logic        rxd_in,
	output logic             txd_out,
	output logic             txd_oe_out,
	output logic             tx_event_out,
	output logic             rx_event_out
);

	typedef struct packed {
		serial_multi_slave_pkg::xfer_state_t xfer;
		logic [7:0]  mode;
		logic [7:0]  ctl0;
		logic [7:0]  ctl1;
		logic [7:0]  smr1;
		logic [7:0]  smr2;
		logic [7:0]  smr3;
		logic [7:0]  smr4;
		logic [7:0]  common;
		logic [7:0]  divider;
		logic [7:0]  tx_buf;
		logic [7:0]  rx_buf;
		logic [7:0]  tx_shift;
		logic [7:0]  rx_shift;
		logic [7:0]  brg_cnt;
		logic [4:0]  pre_cnt;
		logic [4:0]  edge_cnt;
		logic [3:0]  sample_cnt;
		logic        tx_buf_empty;
		logic        rx_done;
		logic        overrun;
		logic        sclk;
		logic        sclk_oe;
		logic        txd_bit;
		logic        txd_pin;
		logic        txd_oe;
		logic [2:0]  sclk_sync;
		logic [1:0]  rxd_sync;
		logic        bus_wait;
		logic [31:0] rdata;
		logic        tx_evt;
		logic        rx_evt;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic        bus_req;
	logic        bus_take;
	logic        bus_wr;
	logic        tx_wr_now;
	logic        master;
	logic        clock_edge_polarity;
	logic        clock_phase_select;
	logic        idle_lvl;
	logic        irq_src;
	logic        open_drain;
	logic        clk_edge;
	logic        clk_rise;
	logic        sample_edge;
	logic        start_now;
	logic [31:0] rd_word;

	// Address match, used by the transmit-write start hold-off and the receive-read flag release
	function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] off);
		addr_hit = (addr == off);
	endfunction

	// Prescaled source ticks: f1, f2, f8, f32 from one free-running count
	function automatic logic prescale_tick(input logic [1:0] sel, input logic [4:0] cnt);
		unique case (sel)
			2'h0: prescale_tick = 1'b1;
			2'h1: prescale_tick = cnt[0];
			2'h2: prescale_tick = &cnt[2:0];
			2'h3: prescale_tick = &cnt;
		endcase
	endfunction

	// Mode decode from stored bits
	always_comb begin
		master     = ~st_q.mode[serial_multi_slave_pkg::CLOCK_SOURCE_DIR];
		clock_edge_polarity      = st_q.ctl0[serial_multi_slave_pkg::CLOCK_EDGE_POL];
		clock_phase_select       = st_q.smr3[serial_multi_slave_pkg::CLOCK_PHASE_SEL];
		idle_lvl   = ~(clock_edge_polarity ^ clock_phase_select);
		// Channel 2 keeps its own source bit, the others use the common one
		if (CH_INDEX == 2) begin
			irq_src = st_q.ctl1[serial_multi_slave_pkg::CH2_TX_IRQ_SRC];
		end else if (CH_INDEX == 1) begin
			irq_src = st_q.common[serial_multi_slave_pkg::CH1_TX_IRQ_SRC];
		end else begin
			irq_src = st_q.common[serial_multi_slave_pkg::CH0_TX_IRQ_SRC];
		end
		open_drain = (CH_INDEX == 2) || st_q.ctl0[serial_multi_slave_pkg::TXD_FORMAT_SEL];
	end

	// Read data mux; write-only and unmapped words read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (address_in)
			serial_multi_slave_pkg::RX_BUFFER_OFF: begin
				rd_word[7:0] = st_q.rx_buf;
				rd_word[serial_multi_slave_pkg::RX_OVERRUN_BIT] = st_q.overrun;
			end
			serial_multi_slave_pkg::SERIAL_MODE_OFF:   rd_word[7:0] = st_q.mode;
			serial_multi_slave_pkg::XFER_CONTROL0_OFF: begin
				rd_word[7:0] = st_q.ctl0;
				rd_word[serial_multi_slave_pkg::SHIFT_EMPTY_FLAG] = (st_q.xfer == serial_multi_slave_pkg::ST_IDLE);
			end
			serial_multi_slave_pkg::XFER_CONTROL1_OFF: begin
				rd_word[7:0] = st_q.ctl1;
				rd_word[serial_multi_slave_pkg::TX_BUF_EMPTY] = st_q.tx_buf_empty;
				rd_word[serial_multi_slave_pkg::RX_DONE] = st_q.rx_done;
			end
			serial_multi_slave_pkg::SPECIAL_MODE1_OFF:  rd_word[7:0] = st_q.smr1;
			serial_multi_slave_pkg::SPECIAL_MODE2_OFF:  rd_word[7:0] = st_q.smr2;
			serial_multi_slave_pkg::SPECIAL_MODE3_OFF:  rd_word[7:0] = st_q.smr3;
			serial_multi_slave_pkg::SPECIAL_MODE4_OFF:  rd_word[7:0] = st_q.smr4;
			serial_multi_slave_pkg::COMMON_CONTROL_OFF: rd_word[7:0] = st_q.common;
			default:                                     rd_word = 32'h0000_0000;
		endcase
	end

	// Next state: bus first, then the shifter so hardware sets win
	always_comb begin
		st_d        = st_q;
		st_d.tx_evt = 1'b0;
		st_d.rx_evt = 1'b0;
		st_d.pre_cnt   = st_q.pre_cnt + 5'h01;
		st_d.sclk_sync = {st_q.sclk_sync[1], st_q.sclk_sync[0], sclk_in};
		st_d.rxd_sync  = {st_q.rxd_sync[0], rxd_in};
		clk_edge    = 1'b0;
		clk_rise    = 1'b0;
		sample_edge = 1'b0;
		start_now   = 1'b0;

		// One wait state: data is set up, then the access completes
		bus_req       = read_in | write_in;
		bus_take      = bus_req & ~st_q.bus_wait;
		bus_wr        = write_in & bus_take & byteenable_in[0];
		tx_wr_now     = bus_wr & addr_hit(address_in, serial_multi_slave_pkg::TX_BUFFER_OFF);
		st_d.bus_wait = ~(bus_req & st_q.bus_wait);
		if (bus_req && st_q.bus_wait) begin
			st_d.rdata = read_in ? rd_word : 32'h0000_0000;
		end

		// Register writes; flag bits in the control words are not stored
		if (bus_wr) begin
			unique case (address_in)
				serial_multi_slave_pkg::TX_BUFFER_OFF: begin
					st_d.tx_buf       = writedata_in[7:0];
					st_d.tx_buf_empty = 1'b0;
				end
				serial_multi_slave_pkg::BAUD_DIVIDER_OFF: st_d.divider = writedata_in[7:0];
				serial_multi_slave_pkg::SERIAL_MODE_OFF:  st_d.mode = writedata_in[7:0];
				serial_multi_slave_pkg::XFER_CONTROL0_OFF: begin
					// Handshake bits only stored: flow control never acts in this mode
					st_d.ctl0 = writedata_in[7:0];
					st_d.ctl0[serial_multi_slave_pkg::SHIFT_EMPTY_FLAG] = 1'b0;
					// No format bit on channel 2
					if (CH_INDEX == 2) begin
						st_d.ctl0[serial_multi_slave_pkg::TXD_FORMAT_SEL] = 1'b0;
					end
				end
				serial_multi_slave_pkg::XFER_CONTROL1_OFF: begin
					st_d.ctl1 = writedata_in[7:0];
					st_d.ctl1[serial_multi_slave_pkg::TX_BUF_EMPTY] = 1'b0;
					st_d.ctl1[serial_multi_slave_pkg::RX_DONE] = 1'b0;
				end
				serial_multi_slave_pkg::SPECIAL_MODE1_OFF:  st_d.smr1 = writedata_in[7:0];
				serial_multi_slave_pkg::SPECIAL_MODE2_OFF:  st_d.smr2 = writedata_in[7:0];
				serial_multi_slave_pkg::SPECIAL_MODE3_OFF:  st_d.smr3 = writedata_in[7:0];
				serial_multi_slave_pkg::SPECIAL_MODE4_OFF:  st_d.smr4 = writedata_in[7:0];
				// Multi-clock bits kept for software, never reach the clock path
				serial_multi_slave_pkg::COMMON_CONTROL_OFF: st_d.common = writedata_in[7:0];
				default: st_d.divider = st_q.divider;
			endcase
		end

		// Reading the receive buffer releases it
		if (read_in && bus_take && addr_hit(address_in, serial_multi_slave_pkg::RX_BUFFER_OFF)) begin
			st_d.rx_done = 1'b0;
		end
		// Overrun stays until the receiver is disabled
		if (!st_q.ctl1[serial_multi_slave_pkg::RX_ENABLE]) begin
			st_d.overrun = 1'b0;
		end

		unique case (st_q.xfer)
			serial_multi_slave_pkg::ST_IDLE: begin
				st_d.sclk = idle_lvl;
				// A slave waits for the far clock to sit at its idle level
				if (st_q.mode[2:0] == serial_multi_slave_pkg::MULTI_SLAVE_MODE
						&& st_q.ctl1[serial_multi_slave_pkg::TX_ENABLE]
						&& !st_q.tx_buf_empty && !tx_wr_now
						&& (master || st_q.sclk_sync[1] == idle_lvl)) begin
					start_now         = 1'b1;
					st_d.xfer         = serial_multi_slave_pkg::ST_XFER;
					st_d.tx_shift     = st_q.tx_buf;
					st_d.txd_bit      = st_q.tx_buf[0];
					st_d.tx_buf_empty = 1'b1;
					st_d.tx_evt       = ~irq_src;
					st_d.edge_cnt     = 5'h00;
					st_d.sample_cnt   = 4'h0;
					st_d.brg_cnt      = st_q.divider;
				end
			end
			serial_multi_slave_pkg::ST_XFER: begin
				// Master: half period of n+1 source ticks; slave: synced pin edges
				if (master) begin
					if (prescale_tick(st_q.ctl0[1:0], st_q.pre_cnt)) begin
						if (st_q.brg_cnt == 8'h00) begin
							st_d.brg_cnt = st_q.divider;
							st_d.sclk    = ~st_q.sclk;
							clk_edge     = 1'b1;
							clk_rise     = ~st_q.sclk;
						end else begin
							st_d.brg_cnt = st_q.brg_cnt - 8'h01;
						end
					end
				end else begin
					clk_edge = st_q.sclk_sync[1] ^ st_q.sclk_sync[2];
					clk_rise = st_q.sclk_sync[1];
				end
				sample_edge = clk_rise ^ clock_edge_polarity;
				if (clk_edge) begin
					st_d.edge_cnt = st_q.edge_cnt + 5'h01;
					if (sample_edge && st_q.sample_cnt < serial_multi_slave_pkg::BITS_PER_XFER) begin
						st_d.rx_shift   = {st_q.rxd_sync[1], st_q.rx_shift[7:1]};
						st_d.sample_cnt = st_q.sample_cnt + 4'h1;
						// Seventh bit of a new byte while the old one is unread
						if (st_q.sample_cnt == 4'h6 && st_d.rx_done
								&& st_q.ctl1[serial_multi_slave_pkg::RX_ENABLE]) begin
							st_d.overrun = 1'b1;
						end
						if (st_q.sample_cnt == 4'h7 && st_q.ctl1[serial_multi_slave_pkg::RX_ENABLE]) begin
							st_d.rx_buf  = {st_q.rxd_sync[1], st_q.rx_shift[7:1]};
							st_d.rx_done = 1'b1;
							st_d.rx_evt  = 1'b1;
						end
					end else if (!sample_edge && st_q.sample_cnt != 4'h0
							&& st_q.sample_cnt < serial_multi_slave_pkg::BITS_PER_XFER) begin
						st_d.tx_shift = {1'b0, st_q.tx_shift[7:1]};
						st_d.txd_bit  = st_q.tx_shift[1];
					end
					if (st_d.edge_cnt == serial_multi_slave_pkg::EDGES_PER_XFER) begin
						st_d.xfer   = serial_multi_slave_pkg::ST_IDLE;
						st_d.tx_evt = irq_src;
					end
				end
			end
		endcase

		// Pin drivers; open-drain only ever pulls low
		st_d.sclk_oe = master;
		st_d.txd_pin = open_drain ? 1'b0 : st_d.txd_bit;
		st_d.txd_oe  = open_drain ? ~st_d.txd_bit : 1'b1;
	end

	// State register
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_q              <= '0;
			st_q.xfer         <= serial_multi_slave_pkg::ST_IDLE;
			st_q.mode         <= serial_multi_slave_pkg::REG8_RST;
			st_q.ctl0         <= serial_multi_slave_pkg::REG8_RST;
			st_q.ctl1         <= serial_multi_slave_pkg::CTL1_STORE_RST;
			st_q.tx_buf_empty <= serial_multi_slave_pkg::TX_EMPTY_RST;
			st_q.sclk         <= 1'b1;
			st_q.txd_bit      <= 1'b1;
			st_q.txd_pin      <= 1'b1;
			st_q.txd_oe       <= 1'b1;
			st_q.sclk_sync    <= 3'h7;
			st_q.rxd_sync     <= 2'h3;
			st_q.bus_wait     <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign readdata_out    = st_q.rdata;
	assign waitrequest_out = st_q.bus_wait;
	assign sclk_out        = st_q.sclk;
	assign sclk_oe_out     = st_q.sclk_oe;
	assign txd_out         = st_q.txd_pin;
	assign txd_oe_out      = st_q.txd_oe;
	assign tx_event_out    = st_q.tx_evt;
	assign rx_event_out    = st_q.rx_evt;

	// Cycles since the last serial clock change, for the rate check
	logic [8:0] gap_q;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			gap_q <= 9'h000;
		end else if (start_now || st_d.sclk != st_q.sclk) begin
			gap_q <= 9'h000;
		end else if (gap_q != 9'h1FF) begin
			gap_q <= gap_q + 9'h001;
		end
	end

	property p_clock_dir;
		@(posedge clk_sys_in) disable iff (rst_in)
		!rst_in |=> (sclk_oe_out == !$past(st_q.mode[serial_multi_slave_pkg::CLOCK_SOURCE_DIR]));
	endproperty
	a_clock_dir: assert property (p_clock_dir) else $error("clock drive does not follow direction bit");

	property p_half_period;
		@(posedge clk_sys_in) disable iff (rst_in)
		(st_q.xfer == serial_multi_slave_pkg::ST_XFER && sclk_oe_out && st_q.ctl0[1:0] == 2'h0
			&& $changed(sclk_out) && $stable(st_q.divider))
			|-> ($past(gap_q) == {1'b0, st_q.divider});
	endproperty
	a_half_period: assert property (p_half_period) else $error("serial clock half period wrong");

	property p_rx_done_event;
		@(posedge clk_sys_in) disable iff (rst_in)
		$rose(st_q.rx_done) |-> rx_event_out ##1 !rx_event_out;
	endproperty
	a_rx_done_event: assert property (p_rx_done_event) else $error("receive done without event");

	property p_tx_write_clears;
		@(posedge clk_sys_in) disable iff (rst_in)
		(write_in && !waitrequest_out && byteenable_in[0]
			&& address_in == serial_multi_slave_pkg::TX_BUFFER_OFF) |=> !st_q.tx_buf_empty;
	endproperty
	a_tx_write_clears: assert property (p_tx_write_clears) else $error("buffer write left empty flag set");

	property p_tx_event_load;
		@(posedge clk_sys_in) disable iff (rst_in)
		($rose(st_q.xfer == serial_multi_slave_pkg::ST_XFER) && !$past(irq_src)) |-> tx_event_out;
	endproperty
	a_tx_event_load: assert property (p_tx_event_load) else $error("no event at buffer move");

	property p_tx_event_done;
		@(posedge clk_sys_in) disable iff (rst_in)
		($fell(st_q.xfer == serial_multi_slave_pkg::ST_XFER) && $past(irq_src)) |-> tx_event_out;
	endproperty
	a_tx_event_done: assert property (p_tx_event_done) else $error("no event at end of sending");

	property p_overrun_seventh;
		@(posedge clk_sys_in) disable iff (rst_in)
		$rose(st_q.overrun) |-> (st_q.sample_cnt == 4'h7 && $past(st_q.rx_done));
	endproperty
	a_overrun_seventh: assert property (p_overrun_seventh) else $error("overrun at wrong bit");

	property p_data_on_fall;
		@(posedge clk_sys_in) disable iff (rst_in)
		(st_q.xfer == serial_multi_slave_pkg::ST_XFER && sclk_oe_out && !clock_edge_polarity && $rose(sclk_out))
			|-> $stable(st_q.txd_bit);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall) else $error("data changed on sampling edge");

	property p_no_start_disabled;
		@(posedge clk_sys_in) disable iff (rst_in)
		(st_q.xfer == serial_multi_slave_pkg::ST_IDLE && !st_q.ctl1[serial_multi_slave_pkg::TX_ENABLE])
			|=> (st_q.xfer == serial_multi_slave_pkg::ST_IDLE);
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled) else $error("transfer started while disabled");

endmodule

// ### testbench/serial_far_end.sv
// Far-side serial partner: a slave that answers the channel's master
// clock, or a master that makes the clock when the channel is a slave.
// Assumes the bench resolves the clock and data wires and selects it.
`timescale 1ns/1ns
module serial_far_end (
	input  wire logic       clk_sys_in,
	input  wire logic       pol_in,
	input  wire logic       phase_in,
	input  wire logic       select_n_in,
	input  wire logic       gen_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       sclk_in,
	input  wire logic       txd_in,
	output logic            rxd_out,
	output logic            sclk_out,
	output logic [7:0]      byte_out
);
	int   bits = 0;
	logic tgl  = 1'b0;

	// Own clock rests at the shared idle level between frames
	assign sclk_out = ~(pol_in ^ phase_in) ^ tgl;

	// Sixteen edges, half period of eight cycles
	always @(posedge gen_in) begin
		repeat (16) begin
			repeat (8) @(posedge clk_sys_in);
			tgl <= ~tgl;
		end
	end

	// Bit 0 goes out at select; released line shows the inverse
	always @(negedge select_n_in) begin
		bits = 0;
		rxd_out = byte_in[0];
	end
	always @(posedge select_n_in) rxd_out = ~rxd_out;

	// Sample on the rising edge when polarity is 0, LSB first
	always @(sclk_in) begin
		if (!select_n_in) begin
			if (sclk_in == !pol_in) begin
				byte_out <= {txd_in, byte_out[7:1]};
				bits <= bits + 1;
			end else if (bits > 0 && bits < 8) begin
				rxd_out <= byte_in[bits]; // A change edge before any sample shifts nothing
			end else if (bits == 8) begin
				rxd_out <= ~rxd_out;
			end
		end
	end
endmodule

// ### testbench/serial_multi_slave_tb.sv
// Bench for one clocked serial multi-slave channel (channel 0).
// Assumes the far-side partner model and a pull-up on the data wire.
`timescale 1ns/1ns
module serial_multi_slave_tb;
	localparam logic [5:0] TXB  = serial_multi_slave_pkg::TX_BUFFER_OFF;
	localparam logic [5:0] RXB  = serial_multi_slave_pkg::RX_BUFFER_OFF;
	localparam logic [5:0] DIV  = serial_multi_slave_pkg::BAUD_DIVIDER_OFF;
	localparam logic [5:0] MODE = serial_multi_slave_pkg::SERIAL_MODE_OFF;
	localparam logic [5:0] C0   = serial_multi_slave_pkg::XFER_CONTROL0_OFF;
	localparam logic [5:0] C1   = serial_multi_slave_pkg::XFER_CONTROL1_OFF;
	localparam logic [5:0] SM3  = serial_multi_slave_pkg::SPECIAL_MODE3_OFF;
	localparam logic [5:0] COM  = serial_multi_slave_pkg::COMMON_CONTROL_OFF;
	logic        clk_sys_in = 1'b0, rst_in = 1'b1, read_in = 1'b0, write_in = 1'b0;
	logic        sel_n = 1'b1, gen = 1'b0, pol = 1'b0, ph = 1'b0, prev = 1'b1;
	logic [5:0]  address_in = 6'h00;
	logic [3:0]  byteenable_in = 4'hF;
	logic [31:0] writedata_in = 32'h0000_0000, q, readdata_out;
	logic [7:0]  far_byte = 8'h00, far_got;
	logic        waitrequest_out, sclk_out, sclk_oe_out, txd_out, txd_oe_out;
	logic        tx_event_out, rx_event_out, far_sclk, far_rxd;
	int          miscompares = 0, samples_checked = 0, cyc = 0, edges = 0, last = 0;
	int          ival = 0, txn = 0, rxn = 0, tx_at = 0, e0, t0;
	int          pre[4] = '{1, 2, 8, 32};
	wire         sclk_w = sclk_oe_out ? sclk_out : far_sclk;
	wire         txd_w  = txd_oe_out ? txd_out : 1'b1;

	serial_multi_slave #(.CH_INDEX(0)) DUT (.clk_sys_in, .rst_in, .address_in, .read_in, .write_in,
		.writedata_in, .byteenable_in, .readdata_out, .waitrequest_out, .sclk_in(sclk_w), .sclk_out,
		.sclk_oe_out, .rxd_in(far_rxd), .txd_out, .txd_oe_out, .tx_event_out, .rx_event_out);
	serial_far_end FAR (.clk_sys_in, .pol_in(pol), .phase_in(ph), .select_n_in(sel_n), .gen_in(gen),
		.byte_in(far_byte), .sclk_in(sclk_w), .txd_in(txd_w), .rxd_out(far_rxd), .sclk_out(far_sclk),
		.byte_out(far_got));

	initial forever #20 clk_sys_in = ~clk_sys_in;

	// Edge spacing and event stamps, counted in system cycles
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (sclk_w !== prev) begin
			edges <= edges + 1;
			ival <= cyc - last;
			last <= cyc;
		end
		prev <= sclk_w;
		if (tx_event_out === 1'b1) begin
			txn <= txn + 1;
			tx_at <= cyc;
		end
		if (rx_event_out === 1'b1) rxn <= rxn + 1;
	end

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Avalon cycle: hold until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		address_in <= a;
		writedata_in <= d;
		write_in <= w;
		read_in <= !w;
		do begin
			@(posedge clk_sys_in);
		end while (waitrequest_out !== 1'b0);
		q = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h00_0000, d});
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(q, e);
	endtask

	task automatic cfg(input logic dir, input logic [1:0] src, input logic [7:0] n);
		wr(MODE, {4'h0, dir, 3'h1});
		wr(C0, {1'b0, pol, 2'h1, 2'h0, src});
		wr(SM3, {6'h00, ph, 1'b0});
		wr(DIV, n);
		wr(C1, 8'h05);
	endtask

	// Bounded wait for a whole byte of sixteen edges
	task automatic wait_edges(input int from);
		int n;
		n = 0;
		while (edges < from + 16 && n < 3000) begin
			@(posedge clk_sys_in);
			n++;
		end
		check(edges - from, 32'h0000_0010);
		repeat (6) @(posedge clk_sys_in);
		sel_n <= 1'b1;
		gen <= 1'b0;
	endtask

	task automatic xfer(input logic [7:0] d, input logic peek);
		int from;
		sel_n <= 1'b0;
		from = edges;
		wr(TXB, d);
		if (sclk_oe_out === 1'b0) gen <= 1'b1;
		if (peek) rd(C0, {24'h00_0000, 1'b0, pol, 6'h10});
		wait_edges(from);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys_in);
		miscompares++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rd(C1, 32'h0000_0002);
		rd(C0, 32'h0000_0008);
		rd(6'h2C, 32'h0000_0000);
		$display("test reset done");
		// Every polarity and phase pair, data in both directions
		for (int m = 0; m < 4; m++) begin
			pol = m[0];
			ph = m[1];
			far_byte = 8'hC3 ^ (8'(m) * 8'h11);
			cfg(1'b0, 2'h0, 8'h03);
			check(sclk_out, {31'h0000_0000, ~(pol ^ ph)});
			xfer(8'h5A + 8'(m), 1'b0);
			check(ival, 32'h0000_0004);
			check(far_got, 8'h5A + 8'(m));
			rd(RXB, {24'h00_0000, far_byte});
		end
		check(rxn, 32'h0000_0004);
		$display("test clock modes done");
		// Prescaler choice sets the edge spacing
		for (int s = 0; s < 4; s++) begin
			cfg(1'b0, 2'(s), 8'h01);
			xfer(8'h00, 1'b0);
			check(ival, 2 * pre[s]);
			bus(1'b0, RXB, 32'h0000_0000);
		end
		$display("test baud done");
		// Event at start, then at the end of sending
		pol = 1'b0;
		ph = 1'b0;
		cfg(1'b0, 2'h0, 8'h03);
		wr(COM, 8'h10);
		t0 = txn;
		xfer(8'h11, 1'b1);
		check(ival, 32'h0000_0004);
		check(tx_at < last, 32'h0000_0001);
		wr(COM, 8'h01);
		xfer(8'h12, 1'b0);
		check(tx_at >= last, 32'h0000_0001);
		check(txn - t0, 32'h0000_0002);
		rd(C0, 32'h0000_0018);
		$display("test events done");
		// Second byte before the buffer is read
		wr(C1, 8'h01);
		wr(C1, 8'h05);
		xfer(8'h01, 1'b0);
		bus(1'b0, RXB, 32'h0000_0000);
		check(q & 32'h0000_1000, 32'h0000_1000);
		wr(C1, 8'h01);
		wr(C1, 8'h05);
		bus(1'b0, RXB, 32'h0000_0000);
		check(q & 32'h0000_1000, 32'h0000_0000);
		$display("test overrun done");
		// Receiver off, then transmitter off until enabled
		wr(C1, 8'h01);
		t0 = rxn;
		xfer(8'h33, 1'b0);
		check(rxn - t0, 32'h0000_0000);
		wr(C1, 8'h04);
		e0 = edges;
		wr(TXB, 8'h44);
		repeat (40) @(posedge clk_sys_in);
		check(edges - e0, 32'h0000_0000);
		rd(C1, 32'h0000_0004);
		sel_n <= 1'b0;
		wr(C1, 8'h05);
		wait_edges(e0);
		check(far_got, 8'h44);
		$display("test enables done");
		// Open-drain transmit form
		wr(C0, 8'h30);
		xfer(8'h0F, 1'b0);
		check(txd_out, 1'b0);
		check(far_got, 8'h0F);
		$display("test output format done");
		// Slave: clock from the far side
		pol = 1'b1;
		far_byte = 8'h6E;
		// Drain the unread byte and drop overrun so the slave byte reads clean
		bus(1'b0, RXB, 32'h0000_0000);
		wr(C1, 8'h00);
		cfg(1'b1, 2'h0, 8'h00);
		check(sclk_oe_out, 1'b0);
		xfer(8'hB7, 1'b0);
		check(far_got, 8'hB7);
		rd(RXB, 32'h0000_006E);
		$display("test slave done");
		end_sim();
	end
endmodule
